// [verilog/uhsc_pkg.sv]
package uhsc_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W  = 10;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CHD_EN    = 10'h0F9;
   localparam logic [IDX_W-1:0] IDX_CHE_EN    = 10'h0FA;
   localparam logic [IDX_W-1:0] IDX_RSV_LO    = 10'h0FB;
   localparam logic [IDX_W-1:0] IDX_RSV_HI    = 10'h0FF;
   localparam logic [IDX_W-1:0] IDX_XCVR_RST  = 10'h100;
   localparam logic [IDX_W-1:0] IDX_RSV_101   = 10'h101;
   localparam logic [IDX_W-1:0] IDX_NEGO      = 10'h102;
   localparam logic [IDX_W-1:0] IDX_CHD_CAUSE = 10'h110;
   localparam logic [IDX_W-1:0] IDX_CHE_CAUSE = 10'h111;
   localparam logic [IDX_W-1:0] IDX_RING      = 10'h112;
   localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 10'h113;
   localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 10'h114;

   // Field positions
   localparam int unsigned CAUSE_LSB      = 4;
   localparam int unsigned XCVR_RST_BIT   = 0;
   localparam int unsigned CANCEL_BIT     = 7;
   localparam int unsigned STATE_LSB      = 4;
   localparam int unsigned RING_CHD_BIT   = 3;
   localparam int unsigned RING_CHE_BIT   = 4;
   localparam int unsigned IRQ_CANCEL_BIT = 0;
   localparam int unsigned IRQ_STATE_BIT  = 1;

   // Values after reset
   localparam logic [3:0] EN_RST       = 4'h0;
   localparam logic       XCVR_RST_RST = 1'b0;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;

   // Timing at the bus clock
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned CANCEL_TIME_NS = 100;
   localparam int unsigned CANCEL_CYC     = (CANCEL_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STEP_TIME_NS   = 1000;
   localparam int unsigned STEP_CYC       = STEP_TIME_NS * CLK_MHZ / 1000;

   // Host port states as reported
   typedef enum logic [2:0] {
      ST_RSVD      = 3'b000,
      ST_IDLE      = 3'b001,
      ST_WAIT_CONN = 3'b010,
      ST_DISABLED  = 3'b011,
      ST_USB_RESET = 3'b100,
      ST_OPER      = 3'b101,
      ST_SUSPEND   = 3'b110,
      ST_RESUME    = 3'b111
   } uhsc_state_e;

   // Compound target codes
   localparam logic [3:0] TGT_WC_DIS  = 4'h9;
   localparam logic [3:0] TGT_WC_OP   = 4'hA;
   localparam logic [3:0] TGT_RST_OP  = 4'hC;
   localparam logic [3:0] TGT_SUSP_OP = 4'hE;
   localparam logic [3:0] TGT_RES_OP  = 4'hF;

   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Per-channel interrupt causes, upper nibble order
   typedef struct packed {
      logic size_done;
      logic xfer_acked;
      logic xfer_error;
      logic cond_change;
   } uhsc_cause_s;

endpackage

// [verilog/uhsc_top.sv]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// How it works
// - Channel-d summary flag is high while any latched channel-d cause has its enable set.
// - Channel-e summary flag works the same way with the channel-e enables, bits 7 to 4.
// - Bit 0 of the transceiver reset register holds the host transceiver in reset while one.
// - The transceiver reset register stays accessible in sleep and snooze states.
// - Writing one to bit 7 stops automatic state control, freezing state and timer; connect detection keeps running.
// - The cancel bit clears itself once stopping completes, twenty 200 MHz cycles later.
// - Bits 6 to 4 report the current host state with codes 001 to 111, 000 reserved.
// - Bits 3 to 0 written with 0001 to 0111 request the single target states.
// - Codes 1001, 1010, 1100, 1110 and 1111 chain two states, all others are ignored.
module uhsc_top
   import uhsc_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire uhsc_cause_s       chan_d_cause,
   input  wire uhsc_cause_s       chan_e_cause,
   input  wire logic              device_connect,
   output logic                   chan_d_summary_flag,
   output logic                   chan_e_summary_flag,
   output logic                   host_xcvr_reset_bit,
   output logic                   auto_active,
   output logic [2:0]             current_host_state,
   output logic                   irq
);

   // Counters below must hold the timing constants
   if (CANCEL_CYC < 1 || CANCEL_CYC > 255 || STEP_CYC < 2 || STEP_CYC > 65535) begin
      $error("uhsc_top: timing constants out of range");
   end
   // Bus slave state
   logic             aw_got_ff, nxt_aw_got_ff, w_got_ff, nxt_w_got_ff;
   logic [IDX_W-1:0] wr_idx_ff, nxt_wr_idx_ff;
   logic [7:0]       wdat_ff, nxt_wdat_ff;
   logic             wlane_ff, nxt_wlane_ff;
   logic             bvalid_ff, nxt_bvalid_ff, rvalid_ff, nxt_rvalid_ff;
   logic [1:0]       bresp_ff, nxt_bresp_ff, rresp_ff, nxt_rresp_ff;
   logic [7:0]       rdat_ff, nxt_rdat_ff;
   logic             wr_do;
   logic [IDX_W-1:0] rd_idx;
   // Register state
   logic [3:0]  chd_en_ff, nxt_chd_en_ff, che_en_ff, nxt_che_en_ff;
   logic [3:0]  chd_stat_ff, nxt_chd_stat_ff, che_stat_ff, nxt_che_stat_ff;
   logic        xrst_ff, nxt_xrst_ff, chd_sum_ff, nxt_chd_sum_ff, che_sum_ff, nxt_che_sum_ff;
   logic [1:0]  irq_stat_ff, nxt_irq_stat_ff, irq_mask_ff, nxt_irq_mask_ff;
   logic        chd_hit, che_hit;
   // Sequencer state
   logic        cancel_ff, nxt_cancel_ff, auto_on_ff, nxt_auto_on_ff;
   logic [7:0]  cancel_cnt_ff, nxt_cancel_cnt_ff;
   uhsc_state_e state_ff, nxt_state_ff, chain_dest_ff, nxt_chain_dest_ff;
   logic        chain_ff, nxt_chain_ff;
   logic [15:0] timer_ff, nxt_timer_ff;
   logic        state_evt, cancel_evt;
   logic        wr_nego, wr_go, tgt_ok, tgt_chain;
   uhsc_state_e tgt_first, tgt_dest;
   // Connect pin synchroniser
   logic        conn_s1_ff, conn_s2_ff, conn_s3_ff, conn_ff, nxt_conn_ff;
   function automatic logic mapped(input logic [IDX_W-1:0] idx);
      mapped = (idx >= IDX_CHD_EN && idx <= IDX_NEGO) ||
               (idx >= IDX_CHD_CAUSE && idx <= IDX_IRQ_MASK);
   endfunction
   // Handshake outputs
   assign awready = !aw_got_ff && !bvalid_ff;
   assign wready  = !w_got_ff && !bvalid_ff;
   assign arready = !rvalid_ff;
   assign wr_do   = aw_got_ff && w_got_ff && !bvalid_ff;
   assign rd_idx  = araddr[ADDR_W-1:2];
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign rvalid  = rvalid_ff;
   assign rresp   = rresp_ff;
   assign rdata   = {24'h000000, rdat_ff};
   // Write and read channel next values
   always_comb begin
      nxt_aw_got_ff = aw_got_ff;
      nxt_w_got_ff  = w_got_ff;
      nxt_wr_idx_ff = wr_idx_ff;
      nxt_wdat_ff   = wdat_ff;
      nxt_wlane_ff  = wlane_ff;
      nxt_bvalid_ff = bvalid_ff;
      nxt_bresp_ff  = bresp_ff;
      nxt_rvalid_ff = rvalid_ff;
      nxt_rresp_ff  = rresp_ff;
      nxt_rdat_ff   = rdat_ff;
      if (awvalid && awready) begin
         nxt_aw_got_ff = 1'b1;
         nxt_wr_idx_ff = awaddr[ADDR_W-1:2];
      end
      if (wvalid && wready) begin
         nxt_w_got_ff = 1'b1;
         nxt_wdat_ff  = wdata[7:0];
         nxt_wlane_ff = wstrb[0];
      end
      if (wr_do) begin
         nxt_aw_got_ff = 1'b0;
         nxt_w_got_ff  = 1'b0;
         nxt_bvalid_ff = 1'b1;
         nxt_bresp_ff  = mapped(wr_idx_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
         nxt_bvalid_ff = 1'b0;
      end
      if (arvalid && arready) begin
         nxt_rvalid_ff = 1'b1;
         nxt_rresp_ff  = mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         case (rd_idx)
            IDX_CHD_EN:    nxt_rdat_ff = {chd_en_ff, 4'h0};
            IDX_CHE_EN:    nxt_rdat_ff = {che_en_ff, 4'h0};
            IDX_XCVR_RST:  nxt_rdat_ff = {7'h00, xrst_ff};
            IDX_NEGO:      nxt_rdat_ff = {cancel_ff, state_ff, 4'h0};
            IDX_CHD_CAUSE: nxt_rdat_ff = {chd_stat_ff, 4'h0};
            IDX_CHE_CAUSE: nxt_rdat_ff = {che_stat_ff, 4'h0};
            IDX_RING:      nxt_rdat_ff = {3'h0, che_sum_ff, chd_sum_ff, 3'h0};
            IDX_IRQ_STAT:  nxt_rdat_ff = {6'h00, irq_stat_ff};
            IDX_IRQ_MASK:  nxt_rdat_ff = {6'h00, irq_mask_ff};
            default:       nxt_rdat_ff = 8'h00;
         endcase
      end else if (rvalid_ff && rready) begin
         nxt_rvalid_ff = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff  <= 1'b0;
         wr_idx_ff <= '0;
         wdat_ff   <= 8'h00;
         wlane_ff  <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
         rvalid_ff <= 1'b0;
         rresp_ff  <= RESP_OKAY;
         rdat_ff   <= 8'h00;
      end else begin
         aw_got_ff <= nxt_aw_got_ff;
         w_got_ff  <= nxt_w_got_ff;
         wr_idx_ff <= nxt_wr_idx_ff;
         wdat_ff   <= nxt_wdat_ff;
         wlane_ff  <= nxt_wlane_ff;
         bvalid_ff <= nxt_bvalid_ff;
         bresp_ff  <= nxt_bresp_ff;
         rvalid_ff <= nxt_rvalid_ff;
         rresp_ff  <= nxt_rresp_ff;
         rdat_ff   <= nxt_rdat_ff;
      end
   end
   // Enables, cause latches, summaries and interrupt
   assign chd_hit = |(chd_stat_ff & chd_en_ff);
   assign che_hit = |(che_stat_ff & che_en_ff);
   assign chan_d_summary_flag = chd_sum_ff;
   assign chan_e_summary_flag = che_sum_ff;
   assign host_xcvr_reset_bit = xrst_ff;
   assign irq = |(irq_stat_ff & irq_mask_ff);
   always_comb begin
      logic [7:0] clr;
      clr = (wr_do && wlane_ff) ? wdat_ff : 8'h00;
      nxt_chd_en_ff   = chd_en_ff;
      nxt_che_en_ff   = che_en_ff;
      nxt_xrst_ff     = xrst_ff;
      nxt_irq_mask_ff = irq_mask_ff;
      if (wr_do && wlane_ff) begin
         case (wr_idx_ff)
            IDX_CHD_EN:   nxt_chd_en_ff   = wdat_ff[7:CAUSE_LSB];
            IDX_CHE_EN:   nxt_che_en_ff   = wdat_ff[7:CAUSE_LSB];
            IDX_XCVR_RST: nxt_xrst_ff     = wdat_ff[XCVR_RST_BIT];
            IDX_IRQ_MASK: nxt_irq_mask_ff = wdat_ff[1:0];
            default:      nxt_irq_mask_ff = irq_mask_ff;
         endcase
      end
      // Set wins over a same-cycle write-one clear
      nxt_chd_stat_ff = (chd_stat_ff & ~((wr_idx_ff == IDX_CHD_CAUSE) ? clr[7:4] : 4'h0))
                        | chan_d_cause;
      nxt_che_stat_ff = (che_stat_ff & ~((wr_idx_ff == IDX_CHE_CAUSE) ? clr[7:4] : 4'h0))
                        | chan_e_cause;
      nxt_irq_stat_ff = (irq_stat_ff & ~((wr_idx_ff == IDX_IRQ_STAT) ? clr[1:0] : 2'h0))
                        | {state_evt, cancel_evt};
      nxt_chd_sum_ff  = chd_hit;
      nxt_che_sum_ff  = che_hit;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chd_en_ff   <= EN_RST;
         che_en_ff   <= EN_RST;
         chd_stat_ff <= 4'h0;
         che_stat_ff <= 4'h0;
         xrst_ff     <= XCVR_RST_RST;
         irq_stat_ff <= 2'h0;
         irq_mask_ff <= IRQ_MASK_RST;
         chd_sum_ff  <= 1'b0;
         che_sum_ff  <= 1'b0;
      end else begin
         chd_en_ff   <= nxt_chd_en_ff;
         che_en_ff   <= nxt_che_en_ff;
         chd_stat_ff <= nxt_chd_stat_ff;
         che_stat_ff <= nxt_che_stat_ff;
         xrst_ff     <= nxt_xrst_ff;
         irq_stat_ff <= nxt_irq_stat_ff;
         irq_mask_ff <= nxt_irq_mask_ff;
         chd_sum_ff  <= nxt_chd_sum_ff;
         che_sum_ff  <= nxt_che_sum_ff;
      end
   end
   // Connect detection, three stages, change when last two agree
   assign nxt_conn_ff = (conn_s2_ff == conn_s3_ff) ? conn_s3_ff : conn_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conn_s1_ff <= 1'b0;
         conn_s2_ff <= 1'b0;
         conn_s3_ff <= 1'b0;
         conn_ff    <= 1'b0;
      end else begin
         conn_s1_ff <= device_connect;
         conn_s2_ff <= conn_s1_ff;
         conn_s3_ff <= conn_s2_ff;
         conn_ff    <= nxt_conn_ff;
      end
   end
   // Target code decode; each chained code names its first state
   always_comb begin
      tgt_ok    = 1'b1;
      tgt_chain = 1'b1;
      tgt_first = uhsc_state_e'(wdat_ff[2:0]);
      tgt_dest  = ST_OPER;
      case (wdat_ff[3:0])
         TGT_WC_DIS: begin
            tgt_first = ST_WAIT_CONN;
            tgt_dest  = ST_DISABLED;
         end
         TGT_WC_OP:   tgt_first = ST_WAIT_CONN;
         TGT_RST_OP:  tgt_first = ST_USB_RESET;
         TGT_SUSP_OP: tgt_first = ST_SUSPEND;
         TGT_RES_OP:  tgt_first = ST_RESUME;
         default: begin
            tgt_chain = 1'b0;
            tgt_ok    = (wdat_ff[3] == 1'b0) && (wdat_ff[2:0] != 3'h0);
         end
      endcase
   end
   assign wr_nego = wr_do && wlane_ff && (wr_idx_ff == IDX_NEGO);
   // Target writes are dropped while a cancel is still running
   assign wr_go   = wr_nego && !wdat_ff[CANCEL_BIT] && !cancel_ff && tgt_ok;
   assign auto_active        = auto_on_ff;
   assign current_host_state = state_ff;
   // Host state sequencer
   always_comb begin
      nxt_cancel_ff     = cancel_ff;
      nxt_cancel_cnt_ff = cancel_cnt_ff;
      nxt_auto_on_ff    = auto_on_ff;
      nxt_state_ff      = state_ff;
      nxt_chain_ff      = chain_ff;
      nxt_chain_dest_ff = chain_dest_ff;
      nxt_timer_ff      = timer_ff;
      state_evt         = 1'b0;
      cancel_evt        = 1'b0;
      if (cancel_ff) begin
         nxt_auto_on_ff    = 1'b0;
         nxt_cancel_cnt_ff = cancel_cnt_ff - 8'h01;
         if (cancel_cnt_ff == 8'h01) begin
            nxt_cancel_ff = 1'b0;
            cancel_evt    = 1'b1;
         end
      end else if (wr_nego && wdat_ff[CANCEL_BIT]) begin
         nxt_cancel_ff     = 1'b1;
         nxt_cancel_cnt_ff = CANCEL_CYC[7:0];
         nxt_auto_on_ff    = 1'b0;
      end else if (wr_go) begin
         nxt_auto_on_ff    = 1'b1;
         nxt_state_ff      = tgt_first;
         nxt_chain_ff      = tgt_chain;
         nxt_chain_dest_ff = tgt_dest;
         nxt_timer_ff      = STEP_CYC[15:0];
         state_evt         = 1'b1;
      end else if (auto_on_ff && chain_ff) begin
         // Wait-connect advances on attach, other first states after the dwell
         if ((state_ff == ST_WAIT_CONN) ? conn_ff : (timer_ff == 16'h0001)) begin
            nxt_state_ff = chain_dest_ff;
            nxt_chain_ff = 1'b0;
            state_evt    = 1'b1;
         end else if (state_ff != ST_WAIT_CONN) begin
            nxt_timer_ff = timer_ff - 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cancel_ff     <= 1'b0;
         cancel_cnt_ff <= 8'h00;
         auto_on_ff    <= 1'b0;
         state_ff      <= ST_IDLE;
         chain_ff      <= 1'b0;
         chain_dest_ff <= ST_OPER;
         timer_ff      <= 16'h0000;
      end else begin
         cancel_ff     <= nxt_cancel_ff;
         cancel_cnt_ff <= nxt_cancel_cnt_ff;
         auto_on_ff    <= nxt_auto_on_ff;
         state_ff      <= nxt_state_ff;
         chain_ff      <= nxt_chain_ff;
         chain_dest_ff <= nxt_chain_dest_ff;
         timer_ff      <= nxt_timer_ff;
      end
   end
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence cancel_start_q;
      !cancel_ff ##1 cancel_ff;
   endsequence
   sequence cancel_hold_q;
      cancel_ff ##19 cancel_ff ##1 !cancel_ff; // High for twenty cycles
   endsequence

   chd_gate_a: assert property (chan_d_summary_flag == $past(chd_hit))
      else $error("channel d summary does not follow enabled causes");
   che_gate_a: assert property (chan_e_summary_flag == $past(che_hit))
      else $error("channel e summary does not follow enabled causes");
   xcvr_rst_a: assert property ((wr_do && wlane_ff && wr_idx_ff == IDX_XCVR_RST) |=>
      host_xcvr_reset_bit == $past(wdat_ff[0]))
      else $error("transceiver reset bit not taken from write");
   cancel_freeze_a: assert property ((cancel_ff && $past(cancel_ff)) |->
      ($stable(state_ff) && $stable(timer_ff) && !auto_active))
      else $error("state moved while cancel pending");
   cancel_clear_a: assert property (cancel_start_q |-> cancel_hold_q)
      else $error("cancel bit did not self clear after stop time");
   state_code_a: assert property (current_host_state != ST_RSVD)
      else $error("reserved host state reported");
   simple_tgt_a: assert property ((wr_go && !tgt_chain) |=>
      (current_host_state == $past(wdat_ff[2:0]) && !chain_ff))
      else $error("single target not entered");
   chain_step_a: assert property ((auto_on_ff && chain_ff && state_ff != ST_WAIT_CONN &&
      timer_ff == 16'h0001 && !cancel_ff && !wr_nego) |=> (state_ff == ST_OPER && !chain_ff))
      else $error("chained target did not reach operational");
   start_run_a: assert property (wr_go |=> (auto_active ##1 (auto_active || cancel_ff)))
      else $error("automatic control did not start on target write");

endmodule

// [dv/uhsc_usb_dev.sv]
`timescale 1ns/1ps

// Downstream device on the host port: attaches some cycles after plug-in
module uhsc_usb_dev (
   input  wire logic       aclk,
   input  wire logic       plugged,
   input  wire logic [7:0] attach_cyc,
   output logic            device_connect
);
   logic [7:0] cnt_ff;

   // Pull-up shows after a chosen delay, drops at once when unplugged
   always @(posedge aclk) begin
      if (!plugged) begin
         cnt_ff         <= 8'h00;
         device_connect <= 1'b0;
      end else if (cnt_ff != attach_cyc) begin
         cnt_ff <= cnt_ff + 8'h01;
      end else begin
         device_connect <= 1'b1;
      end
   end
endmodule

// [dv/test_usb_host_state_control.sv]
`timescale 1ns/1ps

module test_usb_host_state_control
   import uhsc_pkg::*;
;
   logic              aclk = 1'b0;
   logic              aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic              awvalid = 1'b0;
   logic              wvalid = 1'b0;
   logic              bready = 1'b0;
   logic              arvalid = 1'b0;
   logic              rready = 1'b0;
   logic [31:0]       wdata = '0;
   logic [3:0]        wstrb = 4'hF;
   uhsc_cause_s       chan_d_cause = '0;
   uhsc_cause_s       chan_e_cause = '0;
   logic              plugged = 1'b0;
   logic [7:0]        attach_cyc = 8'h04;
   logic              awready, wready, bvalid, arready, rvalid, device_connect;
   logic              flag_d, flag_e, xrst, auto_active, irq;
   logic [1:0]        bresp, rresp, bresp_s, rresp_s;
   logic [31:0]       rdata, rdata_s;
   logic [2:0]        current_host_state;
   logic              aw_hs, w_hs, b_hs, ar_hs, r_hs;
   int                mismatches = 0;
   int                checks_done = 0;
   int                cyc = 0;

   uhsc_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .chan_d_cause(chan_d_cause), .chan_e_cause(chan_e_cause),
      .device_connect(device_connect), .chan_d_summary_flag(flag_d),
      .chan_e_summary_flag(flag_e), .host_xcvr_reset_bit(xrst), .auto_active(auto_active),
      .current_host_state(current_host_state), .irq(irq));

   uhsc_usb_dev u_dev (.aclk(aclk), .plugged(plugged), .attach_cyc(attach_cyc),
      .device_connect(device_connect));

   initial begin
      forever #2.5 aclk = ~aclk;
   end

   // Handshakes seen mid-cycle, valid for the coming rising edge
   always @(negedge aclk) begin
      aw_hs   = awvalid & awready;
      w_hs    = wvalid & wready;
      b_hs    = bvalid & bready;
      ar_hs   = arvalid & arready;
      r_hs    = rvalid & rready;
      bresp_s = bresp;
      rresp_s = rresp;
      rdata_s = rdata;
   end

   // Hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) break;
      end
      chk("bresp", {30'h0, er}, {30'h0, bresp_s});
   endtask

   task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] r);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) break;
      end
      d = rdata_s;
      r = rresp_s;
   endtask

   task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      chk("rdata", e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask

   // Stop automatic control and poll until the cancel bit drops
   task automatic cancel();
      logic [31:0] d;
      logic [1:0]  r;
      logic [2:0]  s;
      int          n;
      s = current_host_state;
      wr(IDX_NEGO, 8'h80, RESP_OKAY);
      rd(IDX_NEGO, d, r);
      chk("cancel_set", 32'h1, {31'h0, d[CANCEL_BIT]});
      n = 0;
      while (d[CANCEL_BIT] !== 1'b0 && n < 40) begin
         rd(IDX_NEGO, d, r);
         n++;
      end
      chk("cancel_clear", 32'h0, {31'h0, d[CANCEL_BIT]});
      chk("auto_stop", 32'h0, {31'h0, auto_active});
      chk("state_kept", {29'h0, s}, {29'h0, current_host_state});
   endtask

   function automatic logic [2:0] first_st(input logic [3:0] c);
      case (c)
         4'h9, 4'hA: return ST_WAIT_CONN;
         4'hC:       return ST_USB_RESET;
         4'hE:       return ST_SUSPEND;
         4'hF:       return ST_RESUME;
         default:    return c[2:0];
      endcase
   endfunction

   task automatic go(input logic [3:0] c);
      cancel();
      wr(IDX_NEGO, {4'h0, c}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("state_first", {29'h0, first_st(c)}, {29'h0, current_host_state});
      chk("auto_run", 32'h1, {31'h0, auto_active});
      rdchk(IDX_NEGO, {25'h0, first_st(c), 4'h0}, RESP_OKAY);
   endtask

   task automatic wait_st(input logic [2:0] e, output int n);
      n = 0;
      while (current_host_state !== e && n < 600) begin
         @(posedge aclk);
         n++;
      end
      chk("state_final", {29'h0, e}, {29'h0, current_host_state});
   endtask

   // Main sequence
   initial begin
      logic [3:0]       en, cv, cd;
      logic [IDX_W-1:0] idx_t [7];
      logic [7:0]       rst_t [7];
      logic [3:0]       chain_t [3];
      logic [3:0]       rsv_t [4];
      logic [2:0]       s;
      int               n;
      idx_t = '{IDX_CHD_EN, IDX_CHE_EN, IDX_XCVR_RST, IDX_NEGO, IDX_RSV_LO, IDX_RSV_HI, IDX_RSV_101};
      rst_t = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
      chain_t = '{TGT_RST_OP, TGT_SUSP_OP, TGT_RES_OP};
      rsv_t = '{4'h0, 4'h8, 4'hB, 4'hD};
      void'($urandom(32'hD205));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      bready  <= 1'b1;
      rready  <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 7; i++) rdchk(idx_t[i], {24'h0, rst_t[i]}, RESP_OKAY);
      chk("state_rst", {29'h0, ST_IDLE}, {29'h0, current_host_state});
      rdchk(10'h200, 32'h0, RESP_SLVERR);
      wr(10'h103, 8'hFF, RESP_SLVERR);
      // Cause gating into the summary flags, random enables and causes
      for (int ch = 0; ch < 2; ch++) begin
         for (int k = 0; k < 6; k++) begin
            en = 4'($urandom);
            cv = 4'($urandom_range(15, 1));
            wr(IDX_CHD_EN + 10'(ch), {en, 4'($urandom)}, RESP_OKAY);
            rdchk(IDX_CHD_EN + 10'(ch), {24'h0, en, 4'h0}, RESP_OKAY);
            if (ch == 0) chan_d_cause <= uhsc_cause_s'(cv);
            else chan_e_cause <= uhsc_cause_s'(cv);
            @(posedge aclk);
            chan_d_cause <= '0;
            chan_e_cause <= '0;
            repeat (3) @(posedge aclk);
            chk("summary", {31'h0, |(en & cv)}, {31'h0, ch ? flag_e : flag_d});
            rdchk(IDX_RING, 32'(|(en & cv)) << (RING_CHD_BIT + ch), RESP_OKAY);
            rdchk(IDX_CHD_CAUSE + 10'(ch), {24'h0, cv, 4'h0}, RESP_OKAY);
            wr(IDX_CHD_CAUSE + 10'(ch), 8'hF0, RESP_OKAY);
            repeat (3) @(posedge aclk);
            chk("summary_clr", 32'h0, {31'h0, ch ? flag_e : flag_d});
         end
      end
      // Transceiver reset bit
      wr(IDX_XCVR_RST, 8'h01, RESP_OKAY);
      chk("xcvr_rst", 32'h1, {31'h0, xrst});
      rdchk(IDX_XCVR_RST, 32'h1, RESP_OKAY);
      wr(IDX_XCVR_RST, 8'h00, RESP_OKAY);
      chk("xcvr_rel", 32'h0, {31'h0, xrst});
      // Write with byte lane 0 off leaves the bit alone
      wstrb <= 4'hE;
      wr(IDX_XCVR_RST, 8'h01, RESP_OKAY);
      chk("xcvr_lane", 32'h0, {31'h0, xrst});
      wstrb <= 4'hF;
      // Single target codes
      for (int c = 1; c < 8; c++) go(4'(c));
      // Chains with a fixed first-state dwell
      for (int i = 0; i < 3; i++) begin
         go(chain_t[i]);
         wait_st(ST_OPER, n);
         chk("dwell", 32'h1, {31'h0, n >= int'(STEP_CYC) - 20});
      end
      // Chains waiting on the downstream device
      for (int i = 0; i < 2; i++) begin
         cd = i ? TGT_WC_OP : TGT_WC_DIS;
         plugged <= 1'b0;
         attach_cyc <= 8'($urandom_range(60, 1));
         repeat (10) @(posedge aclk);
         go(cd);
         repeat (50) @(posedge aclk);
         chk("wait_conn", {29'h0, ST_WAIT_CONN}, {29'h0, current_host_state});
         plugged <= 1'b1;
         wait_st(i ? ST_OPER : ST_DISABLED, n);
      end
      // Reserved target codes are ignored
      for (int i = 0; i < 4; i++) begin
         cancel();
         s = current_host_state;
         wr(IDX_NEGO, {4'h0, rsv_t[i]}, RESP_OKAY);
         repeat (3) @(posedge aclk);
         chk("rsv_state", {29'h0, s}, {29'h0, current_host_state});
         chk("rsv_idle", 32'h0, {31'h0, auto_active});
      end
      // Interrupt raise, clear and mask
      wr(IDX_IRQ_STAT, 8'h03, RESP_OKAY);
      wr(IDX_IRQ_MASK, 8'h02, RESP_OKAY);
      rdchk(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
      go(4'h1);
      chk("irq_set", 32'h1, {31'h0, irq});
      wr(IDX_IRQ_STAT, 8'h02, RESP_OKAY);
      chk("irq_clr", 32'h0, {31'h0, irq});
      rdchk(IDX_IRQ_STAT, 32'h1, RESP_OKAY);
      wr(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
      chk("irq_unmask", 32'h1, {31'h0, irq});
      wr(IDX_IRQ_MASK, 8'h00, RESP_OKAY);
      chk("irq_mask", 32'h0, {31'h0, irq});
      // Reset in mid-run brings state and registers back
      wr(IDX_XCVR_RST, 8'h01, RESP_OKAY);
      go(4'h5);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("rst_auto", 32'h0, {31'h0, auto_active});
      rdchk(IDX_NEGO, 32'h10, RESP_OKAY);
      rdchk(IDX_XCVR_RST, 32'h0, RESP_OKAY);
      stop_test();
   end
endmodule
